// File: rtl/vphr_bus_if.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Shared word port between the positioner and the plant controller.
// ----------------------------------------------------------------------
interface vphr_bus_if;
    logic        req;
    logic        wr;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        ack;

    modport device (input req, input wr, input addr, input wdata, output rdata, output ack);
    modport host   (output req, output wr, output addr, output wdata, input rdata, input ack);
endinterface : vphr_bus_if

`default_nettype wire

// File: rtl/vphr_device.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none


module vphr_device
    import vphr_pkg::*;
#(
    parameter int HOLD_CNT  = vphr_pkg::HOLD_CYCLES,
    parameter int ALIVE_CNT = vphr_pkg::ALIVE_CYCLES
) (
    // Clock and reset.
    input  wire logic               I_SYS_CLK,
    input  wire logic               I_RST,
    // Controller side.
    vphr_bus_if.device              bus,
    // Positioner core side.
    input  wire vphr_pkg::vphr_mode_e i_mode,
    input  wire logic               i_shutdown,
    input  wire logic               i_aux_sense,
    input  wire logic               i_loop_interface_on,
    input  wire logic               i_null_point,
    input  wire logic               i_quality_bad,
    input  wire logic               i_backup,
    input  wire logic               i_xdcr_fault,
    input  wire logic               i_link_demand_vld,
    input  wire logic [15:0]        i_link_demand,
    input  wire logic               i_partner_normal,
    input  wire logic               i_partner_local,
    input  wire logic               i_nvm_write_done,
    input  wire logic [15:0]        i_position_feedback,
    input  wire logic [15:0]        i_demand_scale_slope,
    input  wire logic [15:0]        i_demand_scale_offset,
    input  wire logic [15:0]        i_point_status,
    input  wire logic [15:0]        i_module_config,
    input  wire logic [15:0]        i_secondary_config,
    input  wire logic [15:0]        i_module_identity,
    output logic [15:0]             o_position_demand,
    output var vphr_pkg::vphr_cal_e o_cal_request,
    output logic                    o_cal_strobe,
    output logic                    o_partner_quality_bad,
    output logic                    o_partner_alive,
    output logic                    o_partner_backup,
    output logic [15:0]             o_point_status,
    output logic                    o_point_status_we,
    output logic [15:0]             o_module_config,
    output logic                    o_module_config_we
);
    import vphr_pkg::*;

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] rdata;
        logic        ack;
        logic [15:0] demand;
        logic [2:0]  cal;
        logic        cal_stb;
        logic [2:0]  partner;
        logic [15:0] wdata;
        logic        ps_we;
        logic        mc_we;
        logic        alive;
        logic [31:0] alive_cnt;
        logic [31:0] xdcr_cnt;
        logic [31:0] fo_cnt;
        logic        backup_prev;
        logic        dem_err;
        logic        nvm_done;
        logic [15:0] feedback;
    } vphr_dev_s;

    vphr_dev_s q;
    vphr_dev_s d;
    logic [15:0] status;
    logic        mode_normal;
    logic        mode_local;
    logic signed [16:0] diff;

    // ------------------------------------------------------------------
    // Status word assembly.
    // ------------------------------------------------------------------
    always_comb begin
        mode_normal = (i_mode[3:2] == 2'b11);
        mode_local  = (i_mode[3:2] == 2'b10);
        status = 16'h0000;
        status[3:0]           = i_mode;
        status[ST_SHUTDOWN]   = i_shutdown;
        status[ST_AUX_SENSE]  = i_aux_sense;
        status[ST_LOOP_ON]    = i_loop_interface_on;
        status[ST_ALIVE]      = q.alive;
        status[ST_NULL_POINT] = i_null_point;
        status[ST_QUALITY]    = i_quality_bad;
        status[ST_BACKUP]     = i_backup;
        status[ST_XDCR_FAULT] = (q.xdcr_cnt != 32'h0000_0000);
        status[ST_FAILOVER]   = (q.fo_cnt != 32'h0000_0000);
        status[ST_DEMAND_ERR] = q.dem_err;
        status[ST_MODE_MISM]  = (mode_normal && i_partner_local) ||
                                (mode_local && i_partner_normal);
        status[ST_NVM_DONE]   = q.nvm_done;
    end

    // ------------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        d.ack     = 1'b0;
        d.cal_stb = 1'b0;
        d.ps_we   = 1'b0;
        d.mc_we   = 1'b0;
        // Integer division of the readback; a zero slope falls back to identity.
        diff = $signed({i_position_feedback[15], i_position_feedback}) -
               $signed({i_demand_scale_offset[15], i_demand_scale_offset});
        if ((i_demand_scale_slope == RST_SLOPE_ONE) || (i_demand_scale_slope == 16'h0000)) begin
            d.feedback = diff[15:0];
        end else begin
            d.feedback = 16'((diff * 256) / $signed({1'b0, i_demand_scale_slope}));
        end
        if (q.alive_cnt >= 32'(ALIVE_CNT - 1)) begin
            d.alive_cnt = 32'h0000_0000;
            d.alive     = ~q.alive;
        end else begin
            d.alive_cnt = q.alive_cnt + 32'h0000_0001;
        end
        if (i_xdcr_fault) begin
            d.xdcr_cnt = 32'(HOLD_CNT);
        end else if (q.xdcr_cnt != 32'h0000_0000) begin
            d.xdcr_cnt = q.xdcr_cnt - 32'h0000_0001;
        end
        d.backup_prev = i_backup;
        if (i_backup != q.backup_prev) begin
            d.fo_cnt = 32'(HOLD_CNT);
        end else if (q.fo_cnt != 32'h0000_0000) begin
            d.fo_cnt = q.fo_cnt - 32'h0000_0001;
        end
        if (i_link_demand_vld) begin
            d.dem_err = (i_link_demand != q.demand);
        end
        if (i_nvm_write_done) begin
            d.nvm_done = 1'b1;
        end
        if (bus.req && !q.ack) begin
            d.ack = 1'b1;
            if (bus.wr) begin
                unique case (bus.addr)
                    ADDR_HOST_COMMAND: begin
                        // Only bits 0-2 and 4-6 are kept.
                        d.cal     = bus.wdata[2:0];
                        d.cal_stb = 1'b1;
                        d.partner = {bus.wdata[CMD_PARTNER_BACKUP],
                                     bus.wdata[CMD_PARTNER_ALIVE],
                                     bus.wdata[CMD_PARTNER_QUAL]};
                    end
                    ADDR_POSITION_DEMAND: d.demand = bus.wdata;
                    ADDR_POINT_STATUS: begin
                        d.wdata = bus.wdata;
                        d.ps_we = 1'b1;
                    end
                    ADDR_MODULE_CONFIG: begin
                        d.wdata = bus.wdata;
                        d.mc_we = 1'b1;
                    end
                    default: ;
                endcase
            end else begin
                unique case (bus.addr)
                    ADDR_PRIMARY_STATUS: begin
                        d.rdata = status;
                        // Completion flag is read-to-clear; a new event wins.
                        d.nvm_done = i_nvm_write_done;
                    end
                    ADDR_DEMAND_FEEDBACK:  d.rdata = q.feedback;
                    ADDR_POINT_STATUS:     d.rdata = i_point_status;
                    ADDR_MODULE_CONFIG:    d.rdata = i_module_config;
                    ADDR_SECONDARY_CONFIG: d.rdata = i_secondary_config;
                    ADDR_MODULE_IDENTITY:  d.rdata = i_module_identity;
                    default:               d.rdata = RST_WORD;
                endcase
            end
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    assign bus.rdata             = q.rdata;
    assign bus.ack               = q.ack;
    assign o_position_demand     = q.demand;
    assign o_cal_request         = vphr_cal_e'(q.cal);
    assign o_cal_strobe          = q.cal_stb;
    assign o_partner_quality_bad = q.partner[0];
    assign o_partner_alive       = q.partner[1];
    assign o_partner_backup      = q.partner[2];
    assign o_point_status        = q.wdata;
    assign o_point_status_we     = q.ps_we;
    assign o_module_config       = q.wdata;
    assign o_module_config_we    = q.mc_we;

endmodule : vphr_device

`default_nettype wire

// File: rtl/vphr_host.sv
`timescale 1ns/1ps
`default_nettype none

module vphr_host
    import vphr_pkg::*;
(
    // Clock and reset.
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RST,
    // APB slave.
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Device side.
    vphr_bus_if.host         bus
);
    import vphr_pkg::*;

    // ------------------------------------------------------------------
    // Each APB word at byte address 4*index maps to one device word.
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b10
    } vphr_host_e;

    typedef struct packed {
        vphr_host_e  st;
        logic        req;
        logic        wr;
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic [31:0] rdata;
        logic        err;
    } vphr_host_s;

    vphr_host_s q;
    vphr_host_s d;
    logic [15:0] wval;

    always_comb begin
        d = q;
        wval = i_pwdata[15:0];
        unique case (q.st)
            ST_IDLE: begin
                if (i_psel && i_penable) begin
                    d.err = (i_paddr[1:0] != 2'b00) || (i_paddr[7:6] != 2'b00);
                    if (d.err) begin
                        d.rdata = 32'h0000_0000;
                        d.st    = ST_DONE;
                    end else begin
                        if (i_pwrite && (i_paddr[5:2] == ADDR_HOST_COMMAND)) begin
                            // Invalid calibration codes become no request.
                            if ((wval[2:0] == CAL_BAD_5) || (wval[2:0] == CAL_BAD_6)) begin
                                wval[2:0] = CAL_NONE;
                            end
                            wval = wval & CMD_USED_MASK;
                        end
                        d.req   = 1'b1;
                        d.wr    = i_pwrite;
                        d.addr  = i_paddr[5:2];
                        d.wdata = wval;
                        d.st    = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (bus.ack) begin
                    d.req   = 1'b0;
                    d.rdata = {16'h0000, bus.rdata};
                    d.st    = ST_DONE;
                end
            end
            ST_DONE: d.st = ST_IDLE;
            default: d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bus.req    = q.req;
    assign bus.wr     = q.wr;
    assign bus.addr   = q.addr;
    assign bus.wdata  = q.wdata;
    assign o_prdata   = q.rdata;
    assign o_pready   = (q.st == ST_DONE);
    assign o_pslverr  = (q.st == ST_DONE) && q.err;

endmodule : vphr_host

`default_nettype wire

// File: rtl/vphr_pkg.sv
package vphr_pkg;

    // ------------------------------------------------------------------
    // Register map of the device side, in 16-bit word indices.
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_PRIMARY_STATUS   = 4'h8;
    localparam logic [3:0] ADDR_DEMAND_FEEDBACK  = 4'h9;
    localparam logic [3:0] ADDR_HOST_COMMAND     = 4'ha;
    localparam logic [3:0] ADDR_POSITION_DEMAND  = 4'hb;
    localparam logic [3:0] ADDR_POINT_STATUS     = 4'hc;
    localparam logic [3:0] ADDR_MODULE_CONFIG    = 4'hd;
    localparam logic [3:0] ADDR_SECONDARY_CONFIG = 4'he;
    localparam logic [3:0] ADDR_MODULE_IDENTITY  = 4'hf;

    // ------------------------------------------------------------------
    // Operating mode codes in bits 0-3 of the first status word.
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_UNUSED      = 4'b0000,
        MODE_EXERCISE    = 4'b0001,
        MODE_START       = 4'b0010,
        MODE_TEST        = 4'b0011,
        MODE_LOCAL       = 4'b1000,
        MODE_LOCAL_SEAT  = 4'b1001,
        MODE_LOCAL_BACK  = 4'b1010,
        MODE_LOCAL_CAL   = 4'b1011,
        MODE_NORMAL      = 4'b1100,
        MODE_NORMAL_SEAT = 4'b1101,
        MODE_NORMAL_CAL2 = 4'b1110,
        MODE_NORMAL_CAL3 = 4'b1111
    } vphr_mode_e;

    // ------------------------------------------------------------------
    // Status word bit positions.
    // ------------------------------------------------------------------
    localparam int ST_SHUTDOWN   = 4;
    localparam int ST_AUX_SENSE  = 5;
    localparam int ST_LOOP_ON    = 6;
    localparam int ST_ALIVE      = 7;
    localparam int ST_NULL_POINT = 8;
    localparam int ST_QUALITY    = 9;
    localparam int ST_BACKUP     = 10;
    localparam int ST_XDCR_FAULT = 11;
    localparam int ST_FAILOVER   = 12;
    localparam int ST_DEMAND_ERR = 13;
    localparam int ST_MODE_MISM  = 14;
    localparam int ST_NVM_DONE   = 15;

    // ------------------------------------------------------------------
    // Command word fields.
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CAL_NONE      = 3'b000,
        CAL_ZERO_HOT  = 3'b001,
        CAL_TOP_HOT   = 3'b010,
        CAL_FULL      = 3'b011,
        CAL_TO_NULL   = 3'b100,
        CAL_BAD_5     = 3'b101,
        CAL_BAD_6     = 3'b110,
        CAL_FULL_NULL = 3'b111
    } vphr_cal_e;

    localparam int CMD_PARTNER_QUAL   = 4;
    localparam int CMD_PARTNER_ALIVE  = 5;
    localparam int CMD_PARTNER_BACKUP = 6;
    localparam logic [15:0] CMD_USED_MASK = 16'h0077;

    // ------------------------------------------------------------------
    // Reset values and timing.
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_WORD        = 16'h0000;
    localparam logic [15:0] RST_SLOPE_ONE   = 16'h0100;
    localparam int          CLK_HZ          = 20_000_000;
    localparam int          HOLD_TIME_S     = 5;
    localparam int          HOLD_CYCLES     = HOLD_TIME_S * CLK_HZ;
    localparam int          ALIVE_TIME_US   = 10_000;
    localparam int          ALIVE_CYCLES    = ALIVE_TIME_US * (CLK_HZ / 1_000_000);

endpackage : vphr_pkg

// File: tb/test_valve_positioner_host_registers.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Host register bank bench.
// ----------------------------------------------------------------------
module test_valve_positioner_host_registers;
    import vphr_pkg::*;

    // Short hold and alive counts keep the run brief.
    localparam int HOLD  = 50;
    localparam int ALIVE = 8;

    logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, e, saw0, saw1;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r, rnd;
    logic        shut, aux, loop_on, nul, qbad, backup, xf, lvld, pnorm, ploc, nvm;
    logic [15:0] ldem, fb, slope, offs, pst, mcfg, scfg, mid, d, o_dem, o_pst, o_mcfg;
    logic        o_strb, o_pq, o_pa, o_pb, o_pst_we, o_mcfg_we;
    vphr_mode_e  mode;
    vphr_cal_e   o_cal;
    int          miscompares, cmp_count, cycles, strobes, seed, n, pst_wes, mcfg_wes;
    vphr_mode_e  modes [11] = '{MODE_EXERCISE, MODE_START, MODE_TEST, MODE_LOCAL, MODE_LOCAL_SEAT, MODE_LOCAL_BACK,
                                MODE_LOCAL_CAL, MODE_NORMAL, MODE_NORMAL_SEAT, MODE_NORMAL_CAL2, MODE_NORMAL_CAL3};

    vphr_bus_if bus_if ();

    vphr_device #(.HOLD_CNT(HOLD), .ALIVE_CNT(ALIVE)) i_vphr_device (
        .I_SYS_CLK(sys_clk), .I_RST(rst), .bus(bus_if.device), .i_mode(mode), .i_shutdown(shut),
        .i_aux_sense(aux), .i_loop_interface_on(loop_on), .i_null_point(nul), .i_quality_bad(qbad),
        .i_backup(backup), .i_xdcr_fault(xf), .i_link_demand_vld(lvld), .i_link_demand(ldem),
        .i_partner_normal(pnorm), .i_partner_local(ploc), .i_nvm_write_done(nvm), .i_position_feedback(fb),
        .i_demand_scale_slope(slope), .i_demand_scale_offset(offs), .i_point_status(pst),
        .i_module_config(mcfg), .i_secondary_config(scfg), .i_module_identity(mid),
        .o_position_demand(o_dem), .o_cal_request(o_cal), .o_cal_strobe(o_strb),
        .o_partner_quality_bad(o_pq), .o_partner_alive(o_pa), .o_partner_backup(o_pb),
        .o_point_status(o_pst), .o_point_status_we(o_pst_we), .o_module_config(o_mcfg),
        .o_module_config_we(o_mcfg_we));

    vphr_host i_vphr_host (.I_SYS_CLK(sys_clk), .I_RST(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .bus(bus_if.host));

    vphr_bus_sva i_vphr_bus_sva (.I_SYS_CLK(sys_clk), .I_RST(rst), .req(bus_if.req), .wr(bus_if.wr),
        .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .ack(bus_if.ack));

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task automatic chk_word(input logic [31:0] got, input logic [31:0] want);
        cmp_count++;
        if (got !== want) begin
            miscompares++;
            $display("ERROR %0t: word %h, expected %h", $time, got, want);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic want);
        cmp_count++;
        if (got !== want) begin
            miscompares++;
            $display("ERROR %0t: flag %b, expected %b", $time, got, want);
        end
    endtask : chk_bit

    // One transfer; an idle cycle always precedes the setup cycle.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [15:0] st_exp();
        logic mm;
        mm = (mode[3:2] == 2'b11 && ploc) || (mode[3:2] == 2'b10 && pnorm);
        return {1'b0, mm, 3'b000, backup, qbad, nul, 1'b0, loop_on, aux, shut, mode};
    endfunction : st_exp

    function automatic logic [15:0] fb_exp();
        logic [15:0] diff;
        diff = fb - offs;
        return (slope == 16'h0200) ? diff >> 1 : diff;
    endfunction : fb_exp

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (o_strb === 1'b1) strobes++;
        if (o_pst_we === 1'b1) pst_wes++;
        if (o_mcfg_we === 1'b1) mcfg_wes++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    initial begin
        seed = 32'ha442;
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {shut, aux, loop_on, nul, qbad, backup, xf, lvld, pnorm, ploc, nvm} = '0;
        {ldem, fb, offs, pst, mcfg, scfg, mid} = '0;
        slope = 16'h0100;
        mode = MODE_NORMAL;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        chk_word(o_dem, 32'h0000_0000);
        for (int i = 0; i < 44; i++) begin
            rnd = $random(seed);
            @(posedge sys_clk);
            mode <= modes[i % 11];
            {shut, aux, loop_on, nul, qbad, backup, pnorm, ploc} <= rnd[7:0];
            apb(1'b0, 8'h20, 32'h0000_0000);
            chk_word(r & 32'h0000_477f, {16'h0000, st_exp()});
        end
        saw0 = 1'b0;
        saw1 = 1'b0;
        repeat (6) begin
            apb(1'b0, 8'h20, 32'h0000_0000);
            if (r[7] === 1'b1) saw1 = 1'b1;
            else if (r[7] === 1'b0) saw0 = 1'b0 | 1'b1;
        end
        chk_bit(saw0 & saw1, 1'b1);
        repeat (HOLD + 10) @(posedge sys_clk);
        xf <= 1'b1;
        backup <= ~backup;
        @(posedge sys_clk);
        xf <= 1'b0;
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk_bit(r[11], 1'b1);
        chk_bit(r[12], 1'b1);
        chk_bit(r[10], backup);
        repeat (HOLD - 20) @(posedge sys_clk);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk_word({r[12], r[11]}, 32'h0000_0003);
        repeat (HOLD + 10) @(posedge sys_clk);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk_word({r[12], r[11]}, 32'h0000_0000);
        nvm <= 1'b1;
        @(posedge sys_clk);
        nvm <= 1'b0;
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk_bit(r[15], 1'b1);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk_bit(r[15], 1'b0);
        for (int i = 0; i < 3; i++) begin
            rnd = $random(seed);
            d = (i == 0) ? 16'hf9e8 : (i == 1) ? 16'h7ff8 : rnd[15:0];
            apb(1'b1, 8'h2c, {16'h0000, d});
            chk_word(o_dem, {16'h0000, d});
            for (int k = 0; k < 2; k++) begin
                @(posedge sys_clk);
                lvld <= 1'b1;
                ldem <= (k == 0) ? d : ~d;
                @(posedge sys_clk);
                lvld <= 1'b0;
                apb(1'b0, 8'h20, 32'h0000_0000);
                chk_bit(r[13], k == 1);
            end
        end
        for (int c = 0; c < 8; c++) begin
            rnd = $random(seed);
            d = {rnd[15:3], 3'(c)};
            n = strobes;
            apb(1'b1, 8'h28, {16'h0000, d});
            repeat (2) @(posedge sys_clk);
            chk_word(o_cal, (c == 5 || c == 6) ? 0 : c);
            chk_word({o_pb, o_pa, o_pq}, d[6:4]);
            chk_word(strobes, n + 1);
        end
        for (int i = 0; i < 6; i++) begin
            rnd = $random(seed);
            @(posedge sys_clk);
            slope <= (i % 3 == 0) ? 16'h0100 : (i % 3 == 1) ? 16'h0000 : 16'h0200;
            offs <= (i < 3) ? 16'h0000 : {6'h00, rnd[25:17], 1'b0};
            fb <= 16'd2000 + {2'b00, rnd[13:1], 1'b0};
            apb(1'b0, 8'h24, 32'h0000_0000);
            chk_word(r, {16'h0000, fb_exp()});
        end
        rnd = $random(seed);
        @(posedge sys_clk);
        {pst, mcfg} <= rnd;
        scfg <= ~rnd[15:0];
        mid <= rnd[31:16] ^ 16'h5a5a;
        for (int a = 0; a < 4; a++) begin
            apb(1'b0, 8'h30 + 8'(4 * a), 32'h0000_0000);
            chk_word(r, {16'h0000, (a == 0) ? pst : (a == 1) ? mcfg : (a == 2) ? scfg : mid});
        end
        apb(1'b1, 8'h30, 32'hffff_1234);
        chk_word(o_pst, 32'h0000_1234);
        apb(1'b1, 8'h34, {16'h0000, ~rnd[15:0]});
        chk_word(o_mcfg, {16'h0000, ~rnd[15:0]});
        chk_word(pst_wes, 1);
        chk_word(mcfg_wes, 1);
        for (int a = 0; a < 2; a++) begin
            apb(1'b0, 8'h28 + 8'(4 * a), 32'h0000_0000);
            chk_word(r, 32'h0000_0000);
        end
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk_bit(e, 1'b1);
        apb(1'b0, 8'h21, 32'h0000_0000);
        chk_bit(e, 1'b1);
        apb(1'b0, 8'h3c, 32'h0000_0000);
        chk_bit(e, 1'b0);
        conclude();
    end
endmodule : test_valve_positioner_host_registers

`default_nettype wire

// File: tb/vphr_bus_sva.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Word bus checks between controller and positioner.
// ----------------------------------------------------------------------
module vphr_bus_sva (
    // Clock and reset.
    input wire logic        I_SYS_CLK,
    input wire logic        I_RST,
    // Shared word bus.
    input wire logic        req,
    input wire logic        wr,
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic        ack
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);

    ack_pulse_a : assert property (ack |=> !ack)
        else $error("ack stood longer than one cycle");
    ack_timely_a : assert property (req && !ack |=> ack)
        else $error("ack did not follow a taken request");
    ack_idle_a : assert property (!req |=> !ack)
        else $error("ack without a request");
    req_hold_a : assert property (req && !ack |=> req && $stable(wr) && $stable(addr) && $stable(wdata))
        else $error("request changed before ack");
    req_drop_a : assert property (ack |=> !req)
        else $error("request held past ack");
    reset_quiet_a : assert property ($fell(I_RST) |-> !req && !ack)
        else $error("bus active right after reset");
    // Read data must stay put so the host may latch it one cycle late.
    rdata_hold_a : assert property (!(req && !ack && !wr) |=> $stable(rdata))
        else $error("read data moved without a read");
    mode_code_a : assert property (ack && !wr && addr == 4'h8 |-> rdata[3] || rdata[3:0] inside {4'h1, 4'h2, 4'h3})
        else $error("status read carried an unused mode code");
    wo_read_zero_a : assert property (ack && !wr && (addr == 4'ha || addr == 4'hb) |-> rdata == 16'h0000)
        else $error("write-only register read back nonzero");
endmodule : vphr_bus_sva

`default_nettype wire
